// *** hw/dcc_channel.sv ***
// one dma channel in short address mode with its control register
`timescale 1ns/10ps
// Contract
// RULE1: enable one: take selected requests, move data
// RULE2: enable zero: no transfers, requests ignored
// RULE3: end interrupt only while interrupt enable set
// RULE4: upper select bits both one: full address mode
// RULE5: codes pick timer A events, serial tx/rx
module dcc_channel #(
  parameter int DATA_W = 16  // data word width
) (
  input  wire logic              core_clk,          // 40 MHz system clock
  input  wire logic              rst_n,             // synchronous reset, active low
  input  wire logic [7:0]        avs_address,       // byte address
  input  wire logic              avs_read,          // read request
  input  wire logic              avs_write,         // write request
  input  wire logic [31:0]       avs_writedata,     // write data
  input  wire logic [3:0]        avs_byteenable,    // byte lanes
  output logic      [31:0]       avs_readdata,      // read data
  output logic                   avs_waitrequest,   // stall
  input  wire logic [3:0]        timer_unit_evt,    // timer compare/capture A pulses
  input  wire logic              ser_tx_empty_evt,  // serial port zero tx empty pulse
  input  wire logic              ser_rx_full_evt,   // serial port zero rx full pulse
  input  wire logic              src_valid,         // source word present
  input  wire logic [DATA_W-1:0] src_data,          // source word
  output logic                   src_ack,           // source word consumed
  output logic                   dst_valid,         // word for memory side
  input  wire logic              dst_ready,         // memory side takes word
  output logic [DATA_W-1:0]      dst_data,          // data to write
  output logic [15:0]            dst_addr,          // memory address of word
  output logic                   xfer_end_irq,      // transfer end interrupt request
  output logic                   full_addr_mode     // channel handed to full mode
);
  localparam int BW = DATA_W + 16;  // buffered word: address and data

  logic [7:0]    ctrl;              // channel_control_a
  logic [7:0]    count;             // transfers left
  logic [7:0]    reload;            // count reloaded in repeat mode with the interrupt enable clear
  logic [15:0]   addr;              // memory_addr_reg
  logic          pend;              // activation waiting for data
  logic          end_flag;          // count ran out
  logic          irq_q;             // registered interrupt
  logic          full_q;            // registered full mode flag
  logic          ack_q;             // registered source acknowledge
  logic          waitreq;           // registered waitrequest
  logic [31:0]   rdata;             // registered read data
  logic [7:0]    next_ctrl;
  logic [7:0]    next_count;
  logic [7:0]    next_reload;
  logic [15:0]   next_addr;
  logic          next_pend;
  logic          next_end_flag;
  logic          next_irq;
  logic          next_full;
  logic          next_ack;
  logic          next_waitreq;
  logic [31:0]   next_rdata;
  logic          sel_evt;           // event of the chosen source
  logic          full_sel;          // select code names full mode
  logic          take;              // one transfer happens this cycle
  logic          wr_hit;            // write completes this cycle
  logic          buf_in_ready;      // buffer has room
  logic [BW-1:0] buf_out;           // buffered address and data
  logic [15:0]   step;              // address step per transfer
  logic [DATA_W-1:0] moved;         // data after size masking

  // pick the event that the select code names
  function automatic logic pick_event(input logic [2:0] code, input logic [3:0] tmr,
                                      input logic tx, input logic rx);
    logic r;
    r = 1'b0;
    unique case (code)
      dcc_pkg::SRC_TMR0:   r = tmr[0];   // [RULE5]
      dcc_pkg::SRC_TMR1:   r = tmr[1];   // [RULE5]
      dcc_pkg::SRC_TMR2:   r = tmr[2];   // [RULE5]
      dcc_pkg::SRC_TMR3:   r = tmr[3];   // [RULE5]
      dcc_pkg::SRC_SER_TX: r = tx;       // [RULE5]
      dcc_pkg::SRC_SER_RX: r = rx;       // [RULE5]
      default:             r = 1'b0;     // full mode codes take no short requests
    endcase
    return r;
  endfunction : pick_event

  // register index from byte address; off-word addresses map nowhere
  function automatic logic reg_is(input logic [7:0] a, input logic [7:0] idx);
    return (a[1:0] == 2'h0) && ({2'h0, a[7:2]} == idx);
  endfunction : reg_is

  // two-entry buffer between the source and the memory side
  dcc_buf2 #(
    .WIDTH (BW)
  ) u_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (take),
    .in_ready  (buf_in_ready),
    .in_data   ({addr, moved}),
    .out_valid (dst_valid),
    .out_ready (dst_ready),
    .out_data  (buf_out)
  );

  assign dst_addr = buf_out[BW-1:DATA_W];
  assign dst_data = buf_out[DATA_W-1:0];

  // channel decode: source select, full mode and the transfer strobe
  always_comb begin
    full_sel = (ctrl[dcc_pkg::SRC_MSB:dcc_pkg::SRC_MSB-1] == dcc_pkg::FULL_ADDR_HI); // [RULE4]
    sel_evt  = pick_event(ctrl[dcc_pkg::SRC_MSB:dcc_pkg::SRC_LSB], timer_unit_evt,
                          ser_tx_empty_evt, ser_rx_full_evt);
    // a transfer needs enable, short mode, a pending request, data and room
    take     = ctrl[dcc_pkg::XFER_EN_BIT] && !full_sel && pend
               && src_valid && buf_in_ready;                                  // [RULE1] [RULE2]
    // byte size passes only the low byte; the buffer stalls the channel when full
    moved    = ctrl[dcc_pkg::SIZE_BIT] ? src_data : {{(DATA_W-8){1'b0}}, src_data[7:0]};
    step     = ctrl[dcc_pkg::SIZE_BIT] ? 16'h0002 : 16'h0001;
    wr_hit   = avs_write && !waitreq;
  end

  // next state of the channel and its registers
  always_comb begin
    next_ctrl     = ctrl;
    next_count    = count;
    next_reload   = reload;
    next_addr     = addr;
    next_end_flag = end_flag;
    // requests only latch while enabled; a request in the cycle of a take wins
    next_pend = (pend && !take) || (sel_evt && ctrl[dcc_pkg::XFER_EN_BIT] && !full_sel); // [RULE1]
    if (!ctrl[dcc_pkg::XFER_EN_BIT]) begin
      next_pend = 1'b0;                                    // [RULE2]
    end
    if (take) begin
      next_addr = ctrl[dcc_pkg::DIR_BIT] ? addr - step : addr + step;
      if (count == 8'h01 || count == 8'h00) begin
        // last transfer: repeat with the interrupt enable clear reloads and runs on, else the channel stops
        next_end_flag = 1'b1;
        if (ctrl[dcc_pkg::REPEAT_BIT] && !ctrl[dcc_pkg::IRQ_EN_BIT]) begin
          next_count = reload;
        end else begin
          next_count = 8'h00;
          next_ctrl[dcc_pkg::XFER_EN_BIT] = 1'b0;
        end
      end else begin
        next_count = count - 8'h01;
      end
    end
    // software writes; a fresh enable clears the finished flag
    if (wr_hit && avs_byteenable[0]) begin
      if (reg_is(avs_address, dcc_pkg::CTRL_A_IDX)) begin
        next_ctrl = avs_writedata[7:0];
        // a count end in the same cycle keeps the flag: the hardware set wins
        if (avs_writedata[dcc_pkg::XFER_EN_BIT] && !(take && count <= 8'h01)) begin
          next_end_flag = 1'b0;
        end
      end
      if (reg_is(avs_address, dcc_pkg::COUNT_IDX)) begin
        next_count  = avs_writedata[7:0];
        next_reload = avs_writedata[7:0];
      end
      if (reg_is(avs_address, dcc_pkg::ADDR_IDX)) begin
        next_addr[7:0] = avs_writedata[7:0];
      end
    end
    if (wr_hit && avs_byteenable[1] && reg_is(avs_address, dcc_pkg::ADDR_IDX)) begin
      next_addr[15:8] = avs_writedata[15:8];
    end
    next_irq  = next_end_flag && next_ctrl[dcc_pkg::IRQ_EN_BIT];  // [RULE3]
    next_full = (next_ctrl[dcc_pkg::SRC_MSB:dcc_pkg::SRC_MSB-1]
                 == dcc_pkg::FULL_ADDR_HI);                       // [RULE4]
    next_ack  = take;
  end

  // bus answer: one wait cycle, then the request completes
  always_comb begin
    next_waitreq = !((avs_read || avs_write) && waitreq);
    next_rdata   = rdata;
    if (avs_read && waitreq) begin
      next_rdata = 32'h0000_0000;   // unmapped addresses read zero
      if (reg_is(avs_address, dcc_pkg::CTRL_A_IDX)) begin
        next_rdata = {24'h00_0000, ctrl};
      end else if (reg_is(avs_address, dcc_pkg::COUNT_IDX)) begin
        next_rdata = {16'h0000, reload, count};
      end else if (reg_is(avs_address, dcc_pkg::STATUS_IDX)) begin
        next_rdata = {28'h000_0000, dst_valid, full_sel, end_flag, pend};
      end else if (reg_is(avs_address, dcc_pkg::ADDR_IDX)) begin
        next_rdata = {16'h0000, addr};
      end
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl     <= dcc_pkg::CTRL_A_RESET;
      count    <= dcc_pkg::COUNT_RESET;
      reload   <= dcc_pkg::COUNT_RESET;
      addr     <= dcc_pkg::ADDR_RESET;
      pend     <= 1'b0;
      end_flag <= 1'b0;
      irq_q    <= 1'b0;
      full_q   <= 1'b0;
      ack_q    <= 1'b0;
      waitreq  <= 1'b1;
      rdata    <= 32'h0000_0000;
    end else begin
      ctrl     <= next_ctrl;
      count    <= next_count;
      reload   <= next_reload;
      addr     <= next_addr;
      pend     <= next_pend;
      end_flag <= next_end_flag;
      irq_q    <= next_irq;
      full_q   <= next_full;
      ack_q    <= next_ack;
      waitreq  <= next_waitreq;
      rdata    <= next_rdata;
    end
  end

  assign avs_readdata    = rdata;
  assign avs_waitrequest = waitreq;
  assign xfer_end_irq    = irq_q;
  assign full_addr_mode  = full_q;
  // src_ack comes a cycle after the take; hazard: the source must not advance on its own
  assign src_ack         = ack_q;
endmodule : dcc_channel

// *** common/dcc_pkg.sv ***
// constants shared by the dma channel control block
package dcc_pkg;
  // register indices; the byte address on the bus is the index times four
  localparam logic [7:0] CTRL_A_IDX     = 8'h27;  // channel_control_a
  localparam logic [7:0] COUNT_IDX      = 8'h28;  // transfer count / reload
  localparam logic [7:0] STATUS_IDX     = 8'h29;  // channel state, read only
  localparam logic [7:0] ADDR_IDX       = 8'h2A;  // memory_addr_reg
  localparam logic [7:0] CTRL_A_RESET   = 8'h00;  // channel_control_a after reset
  localparam logic [7:0] COUNT_RESET    = 8'h00;  // count after reset
  localparam logic [15:0] ADDR_RESET    = 16'h0000; // address after reset
  // field positions in channel_control_a
  localparam int XFER_EN_BIT   = 7;  // channel_xfer_enable
  localparam int SIZE_BIT      = 6;  // xfer_size_sel, 1 = word
  localparam int DIR_BIT       = 5;  // addr_step_dir, 1 = decrement
  localparam int REPEAT_BIT    = 4;  // repeat_sel
  localparam int IRQ_EN_BIT    = 3;  // xfer_end_irq_en
  localparam int SRC_MSB       = 2;  // activation_src_bit2
  localparam int SRC_LSB       = 0;  // activation_src_bit0
  // activation source codes
  localparam logic [2:0] SRC_TMR0     = 3'h0;
  localparam logic [2:0] SRC_TMR1     = 3'h1;
  localparam logic [2:0] SRC_TMR2     = 3'h2;
  localparam logic [2:0] SRC_TMR3     = 3'h3;
  localparam logic [2:0] SRC_SER_TX   = 3'h4;
  localparam logic [2:0] SRC_SER_RX   = 3'h5;
  localparam logic [1:0] FULL_ADDR_HI = 2'h3;  // upper two select bits for full mode
endpackage : dcc_pkg

// *** hw/dcc_buf2.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module dcc_buf2 #(
  parameter int WIDTH = 32  // word width
) (
  input  wire logic             core_clk,   // system clock
  input  wire logic             rst_n,      // synchronous reset, active low
  input  wire logic             in_valid,   // word offered
  output logic                  in_ready,   // room for a word
  input  wire logic [WIDTH-1:0] in_data,    // word in
  output logic                  out_valid,  // word available
  input  wire logic             out_ready,  // receiver takes word
  output logic      [WIDTH-1:0] out_data    // word out
);
  logic [WIDTH-1:0] mem [2];          // storage for the two entries
  logic             wptr;             // next slot to fill
  logic             rptr;             // oldest slot
  logic [1:0]       fill;             // entries held
  logic             next_wptr;
  logic             next_rptr;
  logic [1:0]       next_fill;
  logic             push;
  logic             pop;

  // pointer and fill bookkeeping; full and empty follow the real count
  always_comb begin
    push      = in_valid && (fill != 2'h2);
    pop       = out_valid && out_ready;
    next_wptr = push ? ~wptr : wptr;
    next_rptr = pop ? ~rptr : rptr;
    next_fill = fill + {1'b0, push} - {1'b0, pop};
  end

  // registers only; storage written on push
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wptr <= 1'b0;
      rptr <= 1'b0;
      fill <= 2'h0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      fill <= next_fill;
    end
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  assign in_ready  = (fill != 2'h2);  // stalls the source once both slots hold data
  assign out_valid = (fill != 2'h0);
  assign out_data  = mem[rptr];
endmodule : dcc_buf2

// *** testbench/dcc_channel_assertions.sv ***
// port assertions for the dma channel control block
`timescale 1ns/10ps
module dcc_channel_assertions (
  input wire logic        core_clk,         // system clock
  input wire logic        rst_n,            // sync reset, active low
  input wire logic [7:0]  avs_address,      // byte address
  input wire logic        avs_write,        // write request
  input wire logic [31:0] avs_writedata,    // write data
  input wire logic [3:0]  avs_byteenable,   // byte lanes
  input wire logic        avs_waitrequest,  // stall
  input wire logic [3:0]  timer_unit_evt,   // timer events
  input wire logic        ser_tx_empty_evt, // tx empty event
  input wire logic        ser_rx_full_evt,  // rx full event
  input wire logic        src_valid,        // source word present
  input wire logic        src_ack,          // source word consumed
  input wire logic        dst_valid,        // buffer not empty
  input wire logic        dst_ready,        // memory side takes word
  input wire logic        xfer_end_irq,     // end interrupt
  input wire logic        full_addr_mode    // full mode flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic       ctl_wr;        // control write completes
  logic [7:0] sh, next_sh;   // software view of the control byte
  logic [1:0] age, next_age; // cycles since a control write, saturating
  logic [7:0] evts;          // events indexed by select code
  assign ctl_wr = avs_write && !avs_waitrequest && avs_address == 8'h9C && avs_byteenable[0];
  assign evts = {2'b00, ser_rx_full_evt, ser_tx_empty_evt, timer_unit_evt};
  // the shadow misses the hardware clear of enable at count end, so stimulus rewrites it
  always_comb begin
    next_sh = ctl_wr ? avs_writedata[7:0] : sh;
    next_age = ctl_wr ? 2'h0 : ((age == 2'h3) ? age : age + 2'h1);
  end
  // registers only
  always_ff @(posedge core_clk) begin
    sh <= rst_n ? next_sh : 8'h00;
    age <= rst_n ? next_age : 2'h3;
  end
  a_irq_masked: assert property (ctl_wr && !avs_writedata[3] |-> ##2 !xfer_end_irq)
    else $error("end interrupt with its enable clear");
  a_full_sel: assert property (ctl_wr |-> ##2
    (full_addr_mode == ($past(avs_writedata[2:1], 2) == 2'b11)))
    else $error("full mode flag does not follow select bits");
  a_start_xfer: assert property (sh[7] && sh[2:1] != 2'b11 && evts[sh[2:0]] && src_valid
    && dst_ready && !dst_valid |-> ##2 src_ack)
    else $error("selected event not served in two cycles");
  a_off_idle: assert property (!sh[7] && age == 2'h3 |-> !src_ack)
    else $error("transfer while channel disabled");
  a_full_idle: assert property (sh[2:1] == 2'b11 && age == 2'h3 |-> !src_ack)
    else $error("short transfer in full address mode");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule : dcc_channel_assertions
bind dcc_channel dcc_channel_assertions dcc_channel_assertions_i (.core_clk, .rst_n,
  .avs_address, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
  .timer_unit_evt, .ser_tx_empty_evt, .ser_rx_full_evt, .src_valid, .src_ack,
  .dst_valid, .dst_ready, .xfer_end_irq, .full_addr_mode);

// *** testbench/dcc_src_model.sv ***
// source side model: offers numbered words until the channel takes them
`timescale 1ns/10ps
module dcc_src_model (
  input  wire logic   core_clk,  // system clock
  input  wire logic   rst_n,     // sync reset, active low
  input  wire logic   src_ack,   // word consumed
  output logic        src_valid, // word present
  output logic [15:0] src_data   // word offered
);
  logic [7:0] seq; // words handed over so far
  // quiet for one cycle after each ack, then the next word
  always_ff @(posedge core_clk) begin
    seq <= !rst_n ? 8'h00 : (src_ack ? seq + 8'h01 : seq);
    src_valid <= rst_n && !src_ack;
  end
  // an idle line shows an inverted pattern so a stale take is caught
  assign src_data = src_valid ? {8'hA5, seq} : {8'h5A, ~seq};
endmodule : dcc_src_model

// *** testbench/test_dcc_channel.sv ***
// self-checking bench for the dma channel control block
`timescale 1ns/10ps
module test_dcc_channel;
  logic        core_clk = 1'b0, rst_n = 1'b0;   // clock and reset
  logic [7:0]  avs_address = 8'h00;             // bus address
  logic        avs_read = 1'b0, avs_write = 1'b0; // bus strobes
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd; // bus data
  logic        avs_waitrequest, src_valid, src_ack, dst_valid, dst_ready = 1'b1; // handshakes
  logic [3:0]  timer_unit_evt = 4'h0;           // timer events
  logic        ser_tx_empty_evt = 1'b0, ser_rx_full_evt = 1'b0; // serial events
  logic [15:0] src_data, dst_data, dst_addr;    // data path
  logic        xfer_end_irq, full_addr_mode;    // status outputs
  logic [7:0]  exp_seq = 8'h00;                 // next word the memory side should see
  int          n_fail = 0, n_tests = 0, n_ack = 0, na = 0; // counters
  always #12.5 core_clk = ~core_clk;
  dcc_channel #(.DATA_W(16)) dcc_channel_i (.core_clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .timer_unit_evt, .ser_tx_empty_evt, .ser_rx_full_evt, .src_valid, .src_data, .src_ack,
    .dst_valid, .dst_ready, .dst_data, .dst_addr, .xfer_end_irq, .full_addr_mode);
  dcc_src_model dcc_src_model_i (.core_clk, .rst_n, .src_ack, .src_valid, .src_data);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // one avalon cycle, held until waitrequest is seen low
  // waits as long as the slave stalls; only the watchdog ends a hung wait
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge core_clk);
    avs_address <= {idx[5:0], 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // one-cycle event on the source picked by a select code
  task automatic pulse(input int sel);
    @(posedge core_clk);
    timer_unit_evt <= (sel < 4) ? 4'h1 << sel : 4'h0;
    ser_tx_empty_evt <= (sel == 4);
    ser_rx_full_evt <= (sel == 5);
    @(posedge core_clk);
    timer_unit_evt <= 4'h0;
    ser_tx_empty_evt <= 1'b0;
    ser_rx_full_evt <= 1'b0;
  endtask : pulse
  // a transfer lands two cycles after its event; six leaves margin
  task automatic expect_acks(input int want);
    repeat (6) @(posedge core_clk);
    check(n_ack, want);
  endtask : expect_acks
  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  always @(posedge core_clk) begin
    if (src_ack === 1'b1) n_ack <= n_ack + 1;
  end
  // every word leaving the buffer must be the next source word, byte sized
  always @(posedge core_clk) begin
    if (rst_n && dst_valid === 1'b1 && dst_ready === 1'b1) begin
      check(dst_data, {8'h00, exp_seq});
      check(dst_addr, {8'h00, exp_seq});
      exp_seq <= exp_seq + 8'h01;
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(1'b0, dcc_pkg::CTRL_A_IDX, 32'h0);
    check(rd, dcc_pkg::CTRL_A_RESET);
    bus(1'b0, 8'h30, 32'h0);
    check(rd, 32'h0);
    for (int v = 8'hFE; v <= 8'hFF; v++) begin
      bus(1'b1, dcc_pkg::CTRL_A_IDX, v);
      bus(1'b0, dcc_pkg::CTRL_A_IDX, 32'h0);
      check(rd, v);
      check(full_addr_mode, 32'h1);
      pulse(v - 8'hFA);
      expect_acks(na);
    end
    // every short-mode code; a neighbour's event must be ignored first
    for (int s = 0; s < 6; s++) begin
      bus(1'b1, dcc_pkg::COUNT_IDX, 32'h10);
      bus(1'b1, dcc_pkg::CTRL_A_IDX, 32'h80 | s);
      pulse((s + 1) % 6);
      check(full_addr_mode, 32'h0);
      expect_acks(na);
      pulse(s);
      na++;
      expect_acks(na);
    end
    bus(1'b1, dcc_pkg::CTRL_A_IDX, 32'h00);
    pulse(0);
    expect_acks(na);
    // last transfer raises the end interrupt only when its enable is set
    for (int e = 1; e >= 0; e--) begin
      bus(1'b1, dcc_pkg::COUNT_IDX, 32'h1);
      bus(1'b1, dcc_pkg::CTRL_A_IDX, 32'h80 | (e << 3));
      pulse(0);
      na++;
      expect_acks(na);
      check(xfer_end_irq, e);
    end
    // receiver stalls: two words fit, the third waits and is not lost
    bus(1'b1, dcc_pkg::COUNT_IDX, 32'h10);
    bus(1'b1, dcc_pkg::CTRL_A_IDX, 32'h80);
    dst_ready <= 1'b0;
    for (int k = 1; k <= 3; k++) begin
      pulse(0);
      expect_acks(na + ((k < 3) ? k : 2));
    end
    check(n_ack, na + 2);
    dst_ready <= 1'b1;
    expect_acks(na + 3);
    check(dst_valid, 32'h0);
    check(exp_seq, na + 3);
    // byte transfers step the address by one from zero
    bus(1'b0, dcc_pkg::ADDR_IDX, 32'h0);
    check(rd, na + 3);
    test_done();
  end
endmodule : test_dcc_channel
